/* inc/reader_pkg.sv */
// constants for the card reader command handler
`default_nettype none
package reader_pkg;
    localparam logic [7:0] CH_COLON = 8'h3A;
    localparam logic [7:0] CH_CR    = 8'h0D;
    localparam logic [7:0] CH_LF    = 8'h0A;
    localparam logic [7:0] CH_DOT   = 8'h2E;
    localparam logic [7:0] CH_ZERO  = 8'h30;
    localparam logic [7:0] CH_ONE   = 8'h31;
    localparam logic [7:0] CH_N     = 8'h4E;
    localparam logic [7:0] CH_S     = 8'h53;
    localparam logic [7:0] CH_R     = 8'h52;
    localparam logic [7:0] CH_T     = 8'h54;
    localparam logic [7:0] CH_UA    = 8'h41;
    localparam logic [7:0] CH_DIG0  = 8'h30;
    localparam logic [3:0] TYPE_MAX = 4'h6;
    localparam int         MSG_LEN  = 32;
    localparam int         CMD_LEN  = 4;
    // message ids
    localparam logic [2:0] MSG_CRLF  = 3'h0;
    localparam logic [2:0] MSG_INS   = 3'h1;
    localparam logic [2:0] MSG_READ  = 3'h2;
    localparam logic [2:0] MSG_CFG   = 3'h3;
    localparam logic [2:0] MSG_TRK   = 3'h4;
    localparam logic [2:0] MSG_NONE  = 3'h7;
endpackage : reader_pkg
`default_nettype wire

/* verilog/byte_buffer.sv */
// two-entry byte buffer with valid/ready on both sides
`default_nettype none
module byte_buffer #(
    parameter int WIDTH = 8
) (
    input  wire logic             clk,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    logic [WIDTH-1:0] mem_q [2];
    logic             wr_q;
    logic             rd_q;
    logic [1:0]       cnt_q;
    logic             push;
    logic             pop;

    // full/empty from the occupancy count
    assign in_ready  = (cnt_q != 2'd2);
    assign out_valid = (cnt_q != 2'd0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem_q[rd_q];

    // storage writes
    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    // pointers and count
    always_ff @(posedge clk) begin
        if (reset) begin
            wr_q  <= 1'b0;
            rd_q  <= 1'b0;
            cnt_q <= 2'd0;
        end else begin
            if (push) wr_q <= ~wr_q;
            if (pop) rd_q <= ~rd_q;
            cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule : byte_buffer
`default_nettype wire

/* verilog/card_reader_cmd.sv */
// serial command interpreter for the card reader: notify, status and event messages
`default_nettype none
// Behaviour
// - notify command clears/sets flag, replies CRLF
// - notify-only mode sends insert and read messages
// - insertion message text, CRLF, no checksum
// - read-complete message text, CRLF, no checksum
// - configuration query returns one status frame
// - configuration frame layout with periods, checksum
// - four sensor characters in fixed order
// - swipe, flush, arrival flags as digits
// - fourth setting is read direction
// - fifth setting is sentinel inclusion
// - three track enables in order
// - reader type as single digit 0-6
// - track query echoes code, groups, checksum
// - track groups in track order
// - group holds data and start detection
// - checksum is two's complement, high first
// - every response ends CR LF
// - push mode pulses track_data_req instead of sending the read message
// - arrival flag restored from storage at power-up
module card_reader_cmd
    import reader_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic [7:0] rx_data,
    input  wire logic       rx_valid,
    output logic      [7:0] tx_data,
    output logic            tx_valid,
    input  wire logic       tx_ready,
    input  wire logic       saved_arrival,
    output logic            arrival_message_flag,
    output logic            arrival_save_stb,
    input  wire logic       swipe_push_flag,
    input  wire logic       buffer_flush_flag,
    input  wire logic       read_backward,
    input  wire logic       sentinel_include,
    input  wire logic [2:0] track_enable,
    input  wire logic [3:0] reader_type,
    input  wire logic [3:0] load_sensor_pin,
    input  wire logic [2:0] track_data_seen,
    input  wire logic [2:0] track_start_seen,
    input  wire logic       card_inserted,
    input  wire logic       card_read,
    output logic            track_data_req
);
    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_BODY = 2'b01
    } rx_state_t;

    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_BODY = 2'b01,
        TX_SUMH = 2'b10,
        TX_SUML = 2'b11
    } tx_state_t;

    rx_state_t      rx_state_q;
    tx_state_t      tx_state_q;
    logic [7:0]     cmd_q [CMD_LEN];
    logic [2:0]     cmd_cnt_q;
    logic [3:0]     sens_meta_q;
    logic [3:0]     sens_q;
    logic           restore_q;
    logic [2:0]     msg_q;
    logic [5:0]     idx_q;
    logic [7:0]     sum_q;
    logic           ins_pend_q;
    logic           read_pend_q;
    logic [2:0]     cmd_msg;
    logic           cmd_done;
    logic [7:0]     cur_byte;
    logic [5:0]     last_idx;
    logic           has_sum;
    logic [7:0]     chk;
    logic [7:0]     buf_data;
    logic           buf_valid;
    logic           buf_ready;

    function automatic logic [7:0] digit(input logic b);
        digit = b ? CH_ONE : CH_ZERO;
    endfunction : digit

    function automatic logic [7:0] hexc(input logic [3:0] n);
        hexc = (n < 4'hA) ? (CH_DIG0 + {4'h0, n}) : (CH_UA + {4'h0, n} - 8'h0A);
    endfunction : hexc

    // sensor pins are asynchronous, two flops before use
    always_ff @(posedge clk) begin
        if (reset) begin
            sens_meta_q <= 4'h0;
            sens_q      <= 4'h0;
        end else begin
            sens_meta_q <= load_sensor_pin;
            sens_q      <= sens_meta_q;
        end
    end

    // command collection: colon starts, CR ends
    always_ff @(posedge clk) begin
        if (reset) begin
            rx_state_q <= RX_IDLE;
            cmd_cnt_q  <= 3'd0;
            for (int i = 0; i < CMD_LEN; i++) cmd_q[i] <= 8'h00;
        end else if (rx_valid) begin
            case (rx_state_q)
                RX_IDLE: begin
                    if (rx_data == CH_COLON) begin
                        rx_state_q <= RX_BODY;
                        cmd_cnt_q  <= 3'd0;
                    end
                end
                RX_BODY: begin
                    if (rx_data == CH_CR) begin
                        rx_state_q <= RX_IDLE;
                    end else if (rx_data == CH_COLON) begin
                        cmd_cnt_q <= 3'd0;
                    end else if (cmd_cnt_q < 3'(CMD_LEN)) begin
                        cmd_q[cmd_cnt_q[1:0]] <= rx_data;
                        cmd_cnt_q             <= cmd_cnt_q + 3'd1;
                    end
                end
                default: rx_state_q <= RX_IDLE;
            endcase
        end
    end

    // decode when the carriage return arrives
    assign cmd_done = rx_valid && (rx_state_q == RX_BODY) && (rx_data == CH_CR);
    always_comb begin
        cmd_msg = MSG_NONE;
        if (cmd_cnt_q == 3'd2 && cmd_q[0] == CH_N) begin
            cmd_msg = MSG_CRLF;
        end else if (cmd_cnt_q == 3'd2 && cmd_q[0] == CH_S && cmd_q[1] == CH_R) begin
            cmd_msg = MSG_CFG;
        end else if (cmd_cnt_q == 3'd2 && cmd_q[0] == CH_S && cmd_q[1] == CH_T) begin
            cmd_msg = MSG_TRK;
        end
    end

    // arrival flag: loaded from saved copy once after reset, then by command
    always_ff @(posedge clk) begin
        if (reset) begin
            arrival_message_flag <= 1'b0;
            arrival_save_stb     <= 1'b0;
            restore_q            <= 1'b1;
        end else begin
            arrival_save_stb <= 1'b0;
            restore_q        <= 1'b0;
            if (restore_q) begin
                arrival_message_flag <= saved_arrival;
            end else if (cmd_done && cmd_cnt_q == 3'd2 && cmd_q[0] == CH_N) begin
                // other argument leaves every setting as it is
                if (cmd_q[1] == CH_ZERO || cmd_q[1] == CH_ONE) begin
                    arrival_message_flag <= (cmd_q[1] == CH_ONE);
                    arrival_save_stb     <= 1'b1;
                end
            end
        end
    end

    // card events latch until the message can go out; set wins over clear
    always_ff @(posedge clk) begin
        if (reset) begin
            ins_pend_q     <= 1'b0;
            read_pend_q    <= 1'b0;
            track_data_req <= 1'b0;
        end else begin
            track_data_req <= 1'b0;
            if (tx_state_q == TX_IDLE && !(cmd_done && cmd_msg != MSG_NONE)
                    && ins_pend_q) begin
                ins_pend_q <= 1'b0;
            end else if (tx_state_q == TX_IDLE && !(cmd_done && cmd_msg != MSG_NONE)
                    && read_pend_q) begin
                read_pend_q <= 1'b0;
            end
            if (card_inserted && arrival_message_flag) begin
                ins_pend_q <= 1'b1;
            end
            if (card_read && arrival_message_flag && !swipe_push_flag) begin
                read_pend_q <= 1'b1;
            end
            if (card_read && arrival_message_flag && swipe_push_flag) begin
                track_data_req <= 1'b1;
            end
        end
    end

    // byte of the current message at the current index
    always_comb begin
        cur_byte = CH_CR;
        last_idx = 6'd1;
        has_sum  = 1'b0;
        case (msg_q)
            MSG_INS: begin
                last_idx = 6'd14;
                case (idx_q)
                    6'd0:  cur_byte = 8'h43;
                    6'd1:  cur_byte = 8'h61;
                    6'd2:  cur_byte = 8'h72;
                    6'd3:  cur_byte = 8'h64;
                    6'd4:  cur_byte = 8'h20;
                    6'd5:  cur_byte = 8'h49;
                    6'd6:  cur_byte = 8'h6E;
                    6'd7:  cur_byte = 8'h73;
                    6'd8:  cur_byte = 8'h65;
                    6'd9:  cur_byte = 8'h72;
                    6'd10: cur_byte = 8'h74;
                    6'd11: cur_byte = 8'h65;
                    6'd12: cur_byte = 8'h64;
                    6'd13: cur_byte = CH_CR;
                    default: cur_byte = CH_LF;
                endcase
            end
            MSG_READ: begin
                last_idx = 6'd11;
                case (idx_q)
                    6'd0:  cur_byte = 8'h54;
                    6'd1:  cur_byte = 8'h72;
                    6'd2:  cur_byte = 8'h61;
                    6'd3:  cur_byte = 8'h63;
                    6'd4:  cur_byte = 8'h6B;
                    6'd5:  cur_byte = 8'h20;
                    6'd6:  cur_byte = 8'h52;
                    6'd7:  cur_byte = 8'h65;
                    6'd8:  cur_byte = 8'h61;
                    6'd9:  cur_byte = 8'h64;
                    6'd10: cur_byte = CH_CR;
                    default: cur_byte = CH_LF;
                endcase
            end
            MSG_CFG: begin
                // body up to the last period; checksum appended after
                last_idx = 6'd19;
                has_sum  = 1'b1;
                case (idx_q)
                    6'd0:  cur_byte = CH_S;
                    6'd1:  cur_byte = CH_R;
                    6'd2:  cur_byte = CH_COLON;
                    6'd3:  cur_byte = digit(sens_q[0]);
                    6'd4:  cur_byte = digit(sens_q[1]);
                    6'd5:  cur_byte = digit(sens_q[2]);
                    6'd6:  cur_byte = digit(sens_q[3]);
                    6'd8:  cur_byte = digit(swipe_push_flag);
                    6'd9:  cur_byte = digit(buffer_flush_flag);
                    6'd10: cur_byte = digit(arrival_message_flag);
                    6'd11: cur_byte = digit(read_backward);
                    6'd12: cur_byte = digit(sentinel_include);
                    6'd14: cur_byte = digit(track_enable[0]);
                    6'd15: cur_byte = digit(track_enable[1]);
                    6'd16: cur_byte = digit(track_enable[2]);
                    6'd18: cur_byte = CH_DIG0 + {4'h0,
                                      (reader_type > TYPE_MAX) ? TYPE_MAX : reader_type};
                    default: cur_byte = CH_DOT;
                endcase
            end
            MSG_TRK: begin
                last_idx = 6'd11;
                has_sum  = 1'b1;
                case (idx_q)
                    6'd0:  cur_byte = CH_S;
                    6'd1:  cur_byte = CH_T;
                    6'd2:  cur_byte = CH_COLON;
                    6'd3:  cur_byte = digit(track_data_seen[0]);
                    6'd4:  cur_byte = digit(track_start_seen[0]);
                    6'd6:  cur_byte = digit(track_data_seen[1]);
                    6'd7:  cur_byte = digit(track_start_seen[1]);
                    6'd9:  cur_byte = digit(track_data_seen[2]);
                    6'd10: cur_byte = digit(track_start_seen[2]);
                    default: cur_byte = CH_DOT;
                endcase
            end
            default: begin
                cur_byte = (idx_q == 6'd0) ? CH_CR : CH_LF;
            end
        endcase
    end

    // two's complement of running sum
    assign chk = 8'h00 - sum_q;

    // transmit sequencer; next message starts only when idle
    always_ff @(posedge clk) begin
        if (reset) begin
            tx_state_q <= TX_IDLE;
            msg_q      <= MSG_NONE;
            idx_q      <= 6'd0;
            sum_q      <= 8'h00;
        end else begin
            case (tx_state_q)
                TX_IDLE: begin
                    idx_q <= 6'd0;
                    sum_q <= 8'h00;
                    if (cmd_done && cmd_msg != MSG_NONE) begin
                        msg_q      <= cmd_msg;
                        tx_state_q <= TX_BODY;
                    end else if (ins_pend_q) begin
                        msg_q      <= MSG_INS;
                        tx_state_q <= TX_BODY;
                    end else if (read_pend_q) begin
                        msg_q      <= MSG_READ;
                        tx_state_q <= TX_BODY;
                    end
                end
                TX_BODY: begin
                    if (buf_ready) begin
                        sum_q <= sum_q + cur_byte;
                        if (idx_q == last_idx) begin
                            idx_q      <= 6'd0;
                            tx_state_q <= has_sum ? TX_SUMH : TX_IDLE;
                        end else begin
                            idx_q <= idx_q + 6'd1;
                        end
                    end
                end
                TX_SUMH: begin
                    if (buf_ready) tx_state_q <= TX_SUML;
                end
                TX_SUML: begin
                    // then CR LF through the plain trailer
                    if (buf_ready) begin
                        msg_q      <= MSG_CRLF;
                        tx_state_q <= TX_BODY;
                    end
                end
                default: tx_state_q <= TX_IDLE;
            endcase
        end
    end

    // byte presented to the buffer
    always_comb begin
        case (tx_state_q)
            TX_SUMH: buf_data = hexc(chk[7:4]);
            TX_SUML: buf_data = hexc(chk[3:0]);
            default: buf_data = cur_byte;
        endcase
    end
    assign buf_valid = (tx_state_q != TX_IDLE);

    // a stalled receiver fills the buffer and freezes the sequencer
    byte_buffer #(
        .WIDTH(8)
    ) u_tx_buf (
        .clk      (clk),
        .reset    (reset),
        .in_data  (buf_data),
        .in_valid (buf_valid),
        .in_ready (buf_ready),
        .out_data (tx_data),
        .out_valid(tx_valid),
        .out_ready(tx_ready)
    );

    // checks
    property p_notify_set;
        @(posedge clk) disable iff (reset)
        (cmd_done && cmd_cnt_q == 3'd2 && cmd_q[0] == CH_N && cmd_q[1] == CH_ONE && !restore_q)
            |=> arrival_message_flag;
    endproperty
    a_notify_set: assert property (p_notify_set) else $error("notify set failed");

    property p_notify_bad;
        @(posedge clk) disable iff (reset)
        (cmd_done && cmd_q[0] == CH_N && cmd_q[1] != CH_ZERO && cmd_q[1] != CH_ONE
            && !restore_q) |=> $stable(arrival_message_flag);
    endproperty
    a_notify_bad: assert property (p_notify_bad) else $error("bad argument changed flag");

    property p_ins_first;
        @(posedge clk) disable iff (reset)
        (tx_state_q == TX_BODY && msg_q == MSG_INS && idx_q == 6'd0) |-> buf_data == 8'h43;
    endproperty
    a_ins_first: assert property (p_ins_first) else $error("insert message start wrong");

    property p_read_pend;
        @(posedge clk) disable iff (reset)
        (card_read && arrival_message_flag && !swipe_push_flag) |=> read_pend_q;
    endproperty
    a_read_pend: assert property (p_read_pend) else $error("read event lost");

    property p_push_req;
        @(posedge clk) disable iff (reset)
        (card_read && arrival_message_flag && swipe_push_flag)
            |=> track_data_req && !$rose(read_pend_q);
    endproperty
    a_push_req: assert property (p_push_req) else $error("push mode wrong");

    property p_sum_after_body;
        @(posedge clk) disable iff (reset)
        (tx_state_q == TX_SUML && buf_ready) |=> (tx_state_q == TX_BODY && msg_q == MSG_CRLF);
    endproperty
    a_sum_after_body: assert property (p_sum_after_body) else $error("no trailer");

    property p_sum_hi;
        @(posedge clk) disable iff (reset)
        (tx_state_q == TX_SUMH) |-> buf_data == hexc(4'((8'h00 - sum_q) >> 4));
    endproperty
    a_sum_hi: assert property (p_sum_hi) else $error("checksum digit wrong");

    property p_cfg_type;
        @(posedge clk) disable iff (reset)
        (tx_state_q == TX_BODY && msg_q == MSG_CFG && idx_q == 6'd18)
            |-> buf_data >= CH_ZERO && buf_data <= 8'h36;
    endproperty
    a_cfg_type: assert property (p_cfg_type) else $error("type digit out of range");
endmodule : card_reader_cmd
`default_nettype wire

/* bench/host_model.sv */
// host-side model: frames ascii commands and collects the reply bytes
`default_nettype none
module host_model
    import reader_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       slow,
    output logic      [7:0] rx_data,
    output logic            rx_valid,
    input  wire logic [7:0] tx_data,
    input  wire logic       tx_valid,
    output logic            tx_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] got[$];
    logic [1:0] pace_q = 2'h0;
    initial begin
        rx_data  = 8'hFF;
        rx_valid = 1'b0;
        tx_ready = 1'b1;
    end
    // one byte per cycle: colon, body, carriage return
    task automatic send(input string body);
        logic [7:0] b;
        for (int i = -1; i <= body.len(); i++) begin
            b = (i < 0) ? CH_COLON : (i == body.len()) ? CH_CR : 8'(body[i]);
            @(negedge clk);
            rx_data  <= b;
            rx_valid <= 1'b1;
        end
        @(negedge clk);
        rx_data  <= ~b; // idle line must not look like the last byte
        rx_valid <= 1'b0;
    endtask : send
    // slow mode accepts one byte in four, so the buffer sees stalls
    always @(negedge clk) begin
        pace_q   <= pace_q + 2'h1;
        tx_ready <= !slow || (pace_q == 2'h0);
    end
    // capture every accepted byte
    always @(posedge clk) begin
        if (tx_valid === 1'b1 && tx_ready) got.push_back(tx_data);
    end
endmodule : host_model
`default_nettype wire

/* bench/card_reader_cmd_bench.sv */
// self-checking bench for the card reader command handler
`default_nettype none
module card_reader_cmd_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import reader_pkg::*;
    logic       clk, reset, slow, rx_valid, tx_valid, tx_ready, saved_arrival;
    logic       arrival_message_flag, arrival_save_stb, swipe_push_flag, buffer_flush_flag;
    logic       read_backward, sentinel_include, card_inserted, card_read, track_data_req;
    logic [7:0] rx_data, tx_data;
    logic [2:0] track_enable, track_data_seen, track_start_seen;
    logic [3:0] reader_type, load_sensor_pin;
    logic [7:0] exp_q[$];
    logic       exp_flag;
    int         err_count, comparisons, save_cnt, req_cnt;

    card_reader_cmd dut (.clk, .reset, .rx_data, .rx_valid, .tx_data, .tx_valid, .tx_ready,
        .saved_arrival, .arrival_message_flag, .arrival_save_stb, .swipe_push_flag,
        .buffer_flush_flag, .read_backward, .sentinel_include, .track_enable, .reader_type,
        .load_sensor_pin, .track_data_seen, .track_start_seen, .card_inserted, .card_read,
        .track_data_req);
    host_model host (.clk, .slow, .rx_data, .rx_valid, .tx_data, .tx_valid, .tx_ready);

    // clock and pulse counters
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (arrival_save_stb === 1'b1) save_cnt++;
        if (track_data_req === 1'b1) req_cnt++;
    end

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : report_and_stop

    task automatic check_byte(input string what, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, e, g);
        end
    endtask : check_byte
    task automatic check_bit(input string what, input logic e, input logic g);
        check_byte(what, {7'h00, e}, {7'h00, g});
    endtask : check_bit

    // expected frame building; the sum covers everything queued so far
    function automatic logic [7:0] hex_ch(input logic [3:0] d);
        return (d < 4'hA) ? 8'h30 + 8'(d) : 8'h37 + 8'(d);
    endfunction : hex_ch
    task automatic add_str(input string s);
        for (int i = 0; i < s.len(); i++) exp_q.push_back(8'(s[i]));
    endtask : add_str
    task automatic add_bit(input logic b);
        exp_q.push_back(b ? CH_ONE : CH_ZERO);
    endtask : add_bit
    task automatic add_tail(input logic with_sum);
        logic [7:0] sum;
        sum = 8'h00;
        foreach (exp_q[i]) sum += exp_q[i];
        sum = 8'h00 - sum;
        if (with_sum) exp_q.push_back(hex_ch(sum[7:4]));
        if (with_sum) exp_q.push_back(hex_ch(sum[3:0]));
        exp_q.push_back(CH_CR);
        exp_q.push_back(CH_LF);
    endtask : add_tail

    // bounded wait for the whole reply, then extra time to catch stray bytes
    task automatic expect_frame(input string what);
        int n;
        n = 0;
        while (host.got.size() < exp_q.size() && n < 3000) begin
            @(posedge clk);
            n++;
        end
        repeat (40) @(posedge clk);
        check_byte({what, " length"}, 8'(exp_q.size()), 8'(host.got.size()));
        for (int i = 0; i < exp_q.size() && i < host.got.size(); i++)
            check_byte(what, exp_q[i], host.got[i]);
        host.got.delete();
        exp_q.delete();
    endtask : expect_frame

    task automatic notify(input string arg, input logic flag, input int saves);
        int s0;
        s0 = save_cnt;
        host.send({"N", arg});
        add_tail(1'b0);
        exp_flag = flag;
        expect_frame("notify reply");
        check_bit("arrival flag", flag, arrival_message_flag);
        check_byte("save strobes", 8'(saves), 8'(save_cnt - s0));
    endtask : notify

    // cfg is {swipe, flush, backward, sentinel}
    task automatic sr_case(input logic [3:0] ld, input logic [3:0] cfg, input logic [2:0] trk,
                           input logic [3:0] ty, input logic [7:0] ty_ch);
        @(negedge clk);
        load_sensor_pin <= ld;
        {swipe_push_flag, buffer_flush_flag, read_backward, sentinel_include} <= cfg;
        track_enable <= trk;
        reader_type  <= ty;
        repeat (5) @(negedge clk); // sensors pass two sync flops
        host.send("SR");
        add_str("SR:");
        for (int i = 0; i < 4; i++) add_bit(ld[i]);
        add_str(".");
        add_bit(cfg[3]);
        add_bit(cfg[2]);
        add_bit(exp_flag);
        add_bit(cfg[1]);
        add_bit(cfg[0]);
        add_str(".");
        for (int i = 0; i < 3; i++) add_bit(trk[i]);
        add_str(".");
        exp_q.push_back(ty_ch);
        add_str(".");
        add_tail(1'b1);
    endtask : sr_case

    task automatic card_events(input logic push, input string s1, input string s2, input int r);
        int r0;
        @(negedge clk);
        swipe_push_flag <= push;
        repeat (3) @(negedge clk);
        r0 = req_cnt;
        card_inserted <= 1'b1;
        @(negedge clk);
        card_inserted <= 1'b0;
        card_read     <= 1'b1; // back to back: the second event must queue
        @(negedge clk);
        card_read <= 1'b0;
        if (s1.len() > 0) add_str(s1);
        if (s1.len() > 0) add_tail(1'b0);
        if (s2.len() > 0) add_str(s2);
        if (s2.len() > 0) add_tail(1'b0);
        expect_frame("event message");
        check_byte("data requests", 8'(r), 8'(req_cnt - r0));
    endtask : card_events

    // watchdog, far beyond the thousand or so cycles the tests need
    initial begin
        repeat (60000) @(posedge clk);
        err_count++;
        report_and_stop();
    end

    initial begin
        {reset, slow, saved_arrival, swipe_push_flag, buffer_flush_flag} = 5'b11100;
        {read_backward, sentinel_include, card_inserted, card_read} = 4'h0;
        {track_enable, track_data_seen, track_start_seen} = 9'h000;
        {reader_type, load_sensor_pin} = 8'h00;
        {err_count, comparisons, save_cnt, req_cnt} = 128'h0;
        slow = 1'b0;
        repeat (10) @(posedge clk);
        @(negedge clk) reset <= 1'b0;
        repeat (3) @(negedge clk);
        check_bit("restored flag", 1'b1, arrival_message_flag);
        notify("0", 1'b0, 1);
        notify("7", 1'b0, 0);
        notify("1", 1'b1, 1);
        notify("Z", 1'b1, 0);
        notify("0", 1'b0, 1);
        sr_case(4'hD, 4'hF, 3'h3, 4'h3, 8'h33);
        expect_frame("status frame");
        notify("1", 1'b1, 1);
        slow = 1'b1;
        sr_case(4'h2, 4'h5, 3'h4, 4'h9, 8'h36);
        expect_frame("status frame");
        @(negedge clk);
        track_data_seen  = 3'h5;
        track_start_seen = 3'h3;
        host.send("ST");
        add_str("ST:");
        for (int t = 0; t < 3; t++) begin
            add_bit(track_data_seen[t]);
            add_bit(track_start_seen[t]);
            add_str(".");
        end
        add_tail(1'b1);
        expect_frame("track frame");
        slow = 1'b0;
        card_events(1'b0, "Card Inserted", "Track Read", 0);
        card_events(1'b1, "Card Inserted", "", 1);
        notify("0", 1'b0, 1);
        card_events(1'b0, "", "", 0);
        host.send("Q");
        expect_frame("unknown command");
        report_and_stop();
    end
endmodule : card_reader_cmd_bench
`default_nettype wire
